// file: capw_pwm_wdt.sv
/*
 Counter array top: shared counter, prescaler, control registers,
 byte register port, compare channels and the channel 2 watchdog.
 Assumes the master keeps strobes one cycle long and never both at once.
*/
// Our own choices: the strobed register port and the address map.
module capw_pwm_wdt import capw_pkg::*; #(
   parameter int NCH = 3
) (
   input  wire logic           clk,
   input  wire logic           nrst,
   input  wire logic [4:0]     addr,
   input  wire logic [7:0]     wdata,
   input  wire logic           wr,
   input  wire logic           rd,
   input  wire logic           idle,
   output logic      [7:0]     rdata,
   output logic      [NCH-1:0] chan_out,
   output logic                wdt_rst
);

   // ==========================================================
   // Declarations
   logic           cf;
   logic           cr;
   logic [NCH-1:0] ccf;
   logic           idle_suspend;
   logic           watchdog_enable;
   logic           watchdog_lock;
   logic [2:0]     cps;
   logic           reload_access_select;
   logic           cycle_overflow_flag;
   logic           covie;
   logic [1:0]     cycle_length_select;
   logic [15:0]    count;
   logic [15:0]    next_count;
   logic [3:0]     pre;
   logic [3:0]     div;
   logic           wdt_on;
   logic           run;
   logic           tick;
   logic           low_ovf;
   logic           wdt_hit;
   logic           wdt_force;
   logic [15:0]    len_mask;
   logic [2:0]     ch_idx;
   logic           ch_space;
   logic [7:0]     next_rdata;
   logic [7:0]     upd_val;
   logic [NCH-1:0] hit;
   logic [NCH-1:0] wr_mode;
   logic [NCH-1:0] wr_low;
   logic [NCH-1:0] wr_high;
   logic [7:0]     mode_a   [NCH];
   logic [15:0]    match_a  [NCH];
   logic [15:0]    reload_a [NCH];

   // ==========================================================
   // Counter clock
   assign wdt_on = watchdog_enable || watchdog_lock;                                   // R22
   // The watchdog keeps the counter running whatever the run bit says
   assign run    = (cr || wdt_on) && !(idle_suspend && idle);               // R17
   assign tick   = run && (pre == div - DIV_FAST);                  // R25

   always_comb begin
      case (cps)
         CPS_SLOW: div = DIV_SLOW;                                  // R16
         CPS_MID:  div = DIV_MID;
         default:  div = DIV_FAST;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst)
         pre <= '0;
      else if (!run || tick)
         pre <= '0;
      else
         pre <= pre + DIV_FAST;
   end

   // ==========================================================
   // Counter
   assign next_count = count + 16'h0001;
   assign len_mask   = capw_len_mask(cycle_length_select);                        // R23
   assign low_ovf    = count[7:0] == LOW_TOP;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         count <= '0;                                               // R16
      end else begin
         if (tick)
            count <= next_count;                                    // R25
         // Writes to the count are dropped while the watchdog runs
         if (wr && addr == A_CNTL && !wdt_on)
            count[7:0] <= wdata;                                    // R17
         if (wr && addr == A_CNTH && !wdt_on)
            count[15:8] <= wdata;                                   // R17
      end
   end

   // ==========================================================
   // Channel decode
   assign ch_space = addr >= A_CH0;
   assign ch_idx   = 3'((addr - A_CH0) >> 2);
   // Update byte write reloads from the live high byte plus the offset
   assign upd_val  = count[15:8] + match_a[WDT_CH][7:0];            // R19

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gen_ch
         logic       sel;
         logic [7:0] ch_wdata;
         assign sel         = wr && ch_space && ch_idx == 3'(g);
         assign wr_mode[g]  = sel && addr[1:0] == A_CPM;
         assign wr_low[g]   = sel && addr[1:0] == A_CPL;
         assign wr_high[g]  = sel && addr[1:0] == A_CPH;
         assign ch_wdata    = (g == WDT_CH && wdt_on && addr[1:0] == A_CPH)
                              ? upd_val : wdata;                     // R19

         capw_chan u_chan (
            .clk        (clk),
            .nrst       (nrst),
            .tick       (tick),
            .next_count (next_count),
            .cycle_length_select      (cycle_length_select),
            .reload_access_select      (reload_access_select),
            .wdt_mode   (g == WDT_CH && wdt_on),                     // R15
            .wr_mode    (wr_mode[g]),
            .wr_low     (wr_low[g]),
            .wr_high    (wr_high[g]),
            .wdata      (ch_wdata),
            .mode       (mode_a[g]),
            .match      (match_a[g]),
            .reload     (reload_a[g]),
            .pin        (chan_out[g]),
            .hit        (hit[g])
         );
      end
   endgenerate

   // ==========================================================
   // Control register and flags
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cr <= 1'b0;
      end else if (wr && addr == A_CTRL) begin
         // Stored as written; the watchdog overrides it in run
         cr <= wdata[CTL_CR];                                       // R18
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cf <= 1'b0;
      end else if (tick && count == '1) begin
         cf <= 1'b1;                                                // R24
      end else if (wr && addr == A_CTRL) begin
         cf <= wdata[CTL_CF];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ccf <= '0;
      end else begin
         if (wr && addr == A_CTRL)
            ccf <= wdata[NCH-1:0];
         // Hardware set wins over a software clear in the same cycle
         ccf <= (wr && addr == A_CTRL ? wdata[NCH-1:0] : ccf) | hit; // R4
      end
   end

   // ==========================================================
   // Mode register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         watchdog_enable  <= 1'b1;                                             // R16
         watchdog_lock <= 1'b0;
         idle_suspend  <= 1'b0;
         cps   <= CPS_SLOW;                                         // R16
      end else if (wr && addr == A_MODE) begin
         watchdog_enable  <= wdata[MD_WATCHDOG_ENABLE];                                   // R22
         watchdog_lock <= watchdog_lock || wdata[MD_WATCHDOG_LOCK];                         // R22
         if (!wdt_on) begin
            idle_suspend <= wdata[MD_IDLE_SUSPEND];                                 // R17
            cps  <= wdata[MD_CPS+2:MD_CPS];                         // R17
         end
      end
   end

   // ==========================================================
   // PWM configuration register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         reload_access_select <= 1'b0;
         covie <= 1'b0;
         cycle_length_select <= LEN8;
      end else if (wr && addr == A_PWMC) begin
         reload_access_select <= wdata[PC_RELOAD_ACCESS_SELECT];                                  // R8
         covie <= wdata[PC_COVIE];
         cycle_length_select <= wdata[1:0];                                       // R23
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cycle_overflow_flag <= 1'b0;
      end else if (tick && (next_count & len_mask) == '0) begin
         cycle_overflow_flag <= 1'b1;                                              // R11
      end else if (wr && addr == A_PWMC) begin
         cycle_overflow_flag <= wdata[PC_CYCLE_OVERFLOW_FLAG];
      end
   end

   // ==========================================================
   // Watchdog
   assign wdt_hit   = wdt_on && tick && low_ovf
                      && match_a[WDT_CH][15:8] == count[15:8];      // R20
   assign wdt_force = wdt_on && wr && addr == A_CTRL && wdata[WDT_CH]; // R21

   always_ff @(posedge clk) begin
      if (!nrst)
         wdt_rst <= 1'b0;
      else
         wdt_rst <= wdt_hit || wdt_force;                           // R20
   end

   // ==========================================================
   // Read port
   always_comb begin
      next_rdata = '0;
      case (addr)
         A_CTRL:  next_rdata = {cf, cr, 3'h0, ccf};                 // R18
         A_MODE:  next_rdata = {idle_suspend, watchdog_enable, watchdog_lock, 1'b0, cps, 1'b0};
         A_PWMC:  next_rdata = {reload_access_select, cycle_overflow_flag, covie, 3'h0, cycle_length_select};
         A_CNTL:  next_rdata = count[7:0];
         A_CNTH:  next_rdata = count[15:8];
         default: begin
            for (int i = 0; i < NCH; i++) begin
               if (ch_space && ch_idx == 3'(i)) begin
                  case (addr[1:0])
                     A_CPM: next_rdata = mode_a[i];
                     A_CPL: next_rdata = reload_access_select ? reload_a[i][7:0]
                                               : match_a[i][7:0];
                     A_CPH: next_rdata = reload_access_select ? reload_a[i][15:8]
                                               : match_a[i][15:8];
                     default: next_rdata = '0;
                  endcase
               end
            end
         end
      endcase
   end

   // Read data stand for one cycle only, zero otherwise
   always_ff @(posedge clk) begin
      if (!nrst)
         rdata <= '0;
      else if (rd)
         rdata <= next_rdata;
      else
         rdata <= '0;
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_cf_wrap: assert property (tick && count == '1 |=> cf) // R24
      else $error("counter overflow flag not set on wrap");
   a_wdt_run: assert property (wdt_on && !(idle_suspend && idle) && pre == div - DIV_FAST // R17
      |=> count == $past(next_count))
      else $error("counter stopped while watchdog on");
   a_cnt_locked: assert property (wdt_on && wr && addr == A_CNTL // R17
      |=> count == ($past(tick) ? $past(next_count) : $past(count)))
      else $error("count written while watchdog on");
   a_wdt_timeout: assert property (wdt_on && tick && low_ovf // R20
      && match_a[WDT_CH][15:8] == count[15:8] |=> wdt_rst)
      else $error("no watchdog reset on timeout");
   a_wdt_force: assert property (wdt_on && wr && addr == A_CTRL // R21
      && wdata[WDT_CH] |=> wdt_rst)
      else $error("forced watchdog reset missing");
   a_wdt_update: assert property (wdt_on && wr_high[WDT_CH] // R19
      |=> match_a[WDT_CH][15:8] == $past(upd_val))
      else $error("watchdog update value wrong");
   a_lock_hold: assert property (watchdog_lock |=> watchdog_lock && wdt_on) // R22
      else $error("watchdog disabled while locked");
   a_cr_read: assert property (rd && addr == A_CTRL // R18
      |=> rdata[CTL_CR] == $past(cr))
      else $error("run bit read back wrong");
   a_reset_dflt: assert property ($rose(nrst) |-> wdt_on && cps == CPS_SLOW // R16
      && count == '0)
      else $error("reset defaults wrong");
   a_clk_frozen: assert property (wdt_on && wr && addr == A_MODE // R17
      |=> cps == $past(cps))
      else $error("clock select changed under watchdog");

   c_wdt_reset: cover property (wdt_hit);
   c_cf_set: cover property (!cf ##1 cf);
   c_cycle_overflow_flag_set: cover property (!cycle_overflow_flag ##1 cycle_overflow_flag);

endmodule

// file: capw_pkg.sv
/*
 Constants, field layout and types for the counter array PWM and watchdog.
 Assumes a byte-wide register port and a single 100 MHz clock.
*/
// Function
// [R1] 8-bit PWM: output rises on low-byte match, falls on low-byte overflow.
// [R2] 8-bit PWM: low-byte wrap reloads match low byte from match high byte.
// [R3] 8-bit PWM needs compare and pwm enables with cycle length select zero.
// [R4] 8-bit PWM: match sets event flag if enabled; overflow flag every 256.
// [R5] Match low write clears compare enable; match high write sets it.
// [R6] Compare enable clear in any PWM mode holds output low.
// [R7] 8-bit reload 0 gives full duty; 0xFF gives one count of 256.
// [R8] Reload access select steers match addresses to the auto-reload word.
// [R9] N-bit PWM: rise on low N bits match, fall on overflow out of bit N.
// [R10] N-bit overflow sets overflow flag and copies reload into match.
// [R11] N-bit PWM selected by enables and non-8 length; 512/1024/2048 period.
// [R12] 16-bit PWM: rise on full match, fall on counter overflow.
// [R13] 16-bit PWM uses wide enable; overflow sets counter overflow flag.
// [R14] Software times 16-bit match writes to match interrupts.
// [R15] Watchdog on: channel 2 high byte meets count high byte, low is offset.
// [R16] After reset: watchdog on, divide by 12, low count and offset zero.
// [R17] Watchdog on: counter forced, count writes and clock bits frozen.
// [R18] Watchdog on: run bit writes do not stop counter; reads stored value.
// [R19] Update byte write loads count high byte plus offset byte.
// [R20] Watchdog reset when low byte overflows while update byte equals high.
// [R21] Writing 1 to channel 2 flag with watchdog on forces reset.
// [R22] Enable or lock turns watchdog on; lock holds until system reset.
// [R23] One shared two-bit cycle length field for all short PWM channels.
// [R24] Counter overflow flag set on 0xFFFF wrap, cleared only by software.
// [R25] Counter steps once per counter clock tick; compares use that tick.
package capw_pkg;

   // ==========================================================
   // Register map
   localparam logic [4:0] A_CTRL = 5'h00;
   localparam logic [4:0] A_MODE = 5'h01;
   localparam logic [4:0] A_PWMC = 5'h02;
   localparam logic [4:0] A_CNTL = 5'h03;
   localparam logic [4:0] A_CNTH = 5'h04;
   localparam logic [4:0] A_CH0  = 5'h08;
   localparam logic [1:0] A_CPM  = 2'h0;
   localparam logic [1:0] A_CPL  = 2'h1;
   localparam logic [1:0] A_CPH  = 2'h2;

   // ==========================================================
   // Field positions
   localparam int CTL_CF   = 7;
   localparam int CTL_CR   = 6;
   localparam int MD_IDLE_SUSPEND  = 7;
   localparam int MD_WATCHDOG_ENABLE  = 6;
   localparam int MD_WATCHDOG_LOCK = 5;
   localparam int MD_CPS   = 1;
   localparam int PC_RELOAD_ACCESS_SELECT = 7;
   localparam int PC_CYCLE_OVERFLOW_FLAG  = 6;
   localparam int PC_COVIE = 5;
   localparam int CPM_W16  = 7;
   localparam int CPM_ECOM = 6;
   localparam int CPM_MAT  = 3;
   localparam int CPM_PWM  = 1;
   localparam int WDT_CH   = 2;

   // ==========================================================
   // Prescaler divides
   localparam logic [3:0] DIV_SLOW = 4'hc;
   localparam logic [3:0] DIV_MID  = 4'h4;
   localparam logic [3:0] DIV_FAST = 4'h1;
   localparam logic [2:0] CPS_SLOW = 3'h0;
   localparam logic [2:0] CPS_MID  = 3'h1;
   localparam logic [7:0] LOW_TOP  = 8'hff;

   typedef enum logic [1:0] {
      LEN8  = 2'b00,
      LEN9  = 2'b01,
      LEN10 = 2'b10,
      LEN11 = 2'b11
   } capw_len_type;

   typedef enum logic [2:0] {
      CM_OFF   = 3'b000,
      CM_TIMER = 3'b001,
      CM_PWM_ENABLE  = 3'b010,
      CM_PWM16 = 3'b011,
      CM_WDT   = 3'b100
   } capw_chmode_type;

   function automatic logic [15:0] capw_len_mask(input logic [1:0] len);
      case (len)
         LEN8:    capw_len_mask = 16'h00ff;
         LEN9:    capw_len_mask = 16'h01ff;
         LEN10:   capw_len_mask = 16'h03ff;
         LEN11:   capw_len_mask = 16'h07ff;
         default: capw_len_mask = 16'h00ff;
      endcase
   endfunction

endpackage

// file: capw_chan.sv
/*
 One compare channel: mode byte, match word, auto-reload word, output pin.
 Assumes the top supplies the counter's next value and a tick strobe.
*/
module capw_chan import capw_pkg::*; (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        tick,
   input  wire logic [15:0] next_count,
   input  wire logic [1:0]  cycle_length_select,
   input  wire logic        reload_access_select,
   input  wire logic        wdt_mode,
   input  wire logic        wr_mode,
   input  wire logic        wr_low,
   input  wire logic        wr_high,
   input  wire logic [7:0]  wdata,
   output logic      [7:0]  mode,
   output logic      [15:0] match,
   output logic      [15:0] reload,
   output logic             pin,
   output logic             hit
);

   capw_chmode_type chmode;
   logic [15:0] mask;
   logic [15:0] reload_src;
   logic [15:0] cmpv;
   logic        ovf_n;
   logic        ovf16;
   logic        hit_n;
   logic        hit16;
   logic        to_match;

   // ==========================================================
   // Compare
   assign mask       = capw_len_mask(cycle_length_select);                      // R23
   assign ovf_n      = (next_count & mask) == '0;
   assign ovf16      = next_count == '0;
   // Compare against the value in force after a reload, so 0 gives full duty
   assign reload_src = (cycle_length_select == LEN8) ? {match[15:8], match[15:8]} : reload; // R7
   assign cmpv       = ovf_n ? reload_src : match;
   assign hit_n      = ((next_count ^ cmpv) & mask) == '0;         // R25
   assign hit16      = next_count == match;
   assign to_match   = wdt_mode || !reload_access_select;                          // R8

   always_comb begin
      if (wdt_mode)
         chmode = CM_WDT;                                           // R17
      else if (!mode[CPM_ECOM])
         chmode = CM_OFF;
      else if (mode[CPM_PWM] && mode[CPM_W16])
         chmode = CM_PWM16;                                         // R13
      else if (mode[CPM_PWM])
         chmode = CM_PWM_ENABLE;                                          // R3
      else
         chmode = CM_TIMER;
   end

   always_comb begin
      case (chmode)
         CM_PWM_ENABLE:  hit = tick && mode[CPM_MAT] && hit_n;            // R4
         CM_PWM16: hit = tick && mode[CPM_MAT] && hit16;            // R13
         CM_TIMER: hit = tick && mode[CPM_MAT] && hit16;
         default:  hit = 1'b0;
      endcase
   end

   // ==========================================================
   // Output pin
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pin <= 1'b0;
      end else begin
         case (chmode)
            CM_PWM_ENABLE: begin
               if (tick && hit_n)
                  pin <= 1'b1;                                      // R1
               else if (tick && ovf_n)
                  pin <= 1'b0;                                      // R9
            end
            CM_PWM16: begin
               if (tick && hit16)
                  pin <= 1'b1;                                      // R12
               else if (tick && ovf16)
                  pin <= 1'b0;
            end
            CM_OFF: begin
               if (mode[CPM_PWM])
                  pin <= 1'b0;                                      // R6
            end
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         match <= '0;                                               // R16
      end else begin
         if (tick && chmode == CM_PWM_ENABLE && ovf_n) begin
            if (cycle_length_select == LEN8)
               match[7:0] <= match[15:8];                           // R2
            else
               match <= reload;                                     // R10
         end
         // A bus write in the reload cycle wins over the reload
         if (wr_low && to_match)
            match[7:0] <= wdata;
         if (wr_high && to_match)
            match[15:8] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         reload <= '0;
      end else begin
         if (wr_low && !to_match)
            reload[7:0] <= wdata;                                   // R8
         if (wr_high && !to_match)
            reload[15:8] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         mode <= '0;
      end else begin
         if (wr_mode && !wdt_mode)
            mode <= wdata;                                          // R17
         if (wr_low)
            mode[CPM_ECOM] <= 1'b0;                                 // R5
         if (wr_high)
            mode[CPM_ECOM] <= 1'b1;                                 // R5
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_zero_duty: assert property (chmode == CM_OFF && mode[CPM_PWM] |=> !pin) // R6
      else $error("pwm output not low with compare off");
   a_ecom_clear: assert property (wr_low |=> !mode[CPM_ECOM]) // R5
      else $error("low byte write left compare enabled");
   a_short_rise: assert property (tick && chmode == CM_PWM_ENABLE && hit_n |=> pin) // R9
      else $error("short pwm did not rise on match");
   a_short_fall: assert property (tick && chmode == CM_PWM_ENABLE && ovf_n && !hit_n |=> !pin) // R1
      else $error("short pwm did not fall on overflow");
   a_reload_copy: assert property (tick && chmode == CM_PWM_ENABLE && ovf_n && cycle_length_select != LEN8 // R10
      && !wr_low && !wr_high |=> match == $past(reload))
      else $error("reload not copied into match");
   a_wide_rise: assert property (tick && chmode == CM_PWM16 && hit16 |=> pin) // R12
      else $error("wide pwm did not rise on match");
   c_short_pwm: cover property (chmode == CM_PWM_ENABLE && !pin ##1 pin);
   c_wide_pwm: cover property (chmode == CM_PWM16 && pin ##1 !pin);

endmodule

// file: capw_load.sv
/*
 External load on the channel output pins: counts high clocks per pin.
 Assumes the pins are registered levels sampled on the rising clock.
*/
module capw_load (
   input  wire logic        clk,
   input  wire logic        clr,
   input  wire logic [2:0]  pins,
   output logic [2:0][15:0] hi
);
   // ==========================================================
   // High time counters, cleared by the bench before each window
   always_ff @(posedge clk) begin
      for (int i = 0; i < 3; i++) begin
         hi[i] <= clr ? 16'h0000 : hi[i] + 16'(pins[i]);
      end
   end
endmodule

// file: tb_top.sv
/*
 Self-checking bench for the counter array PWM and watchdog top.
 Assumes the byte register port with one-cycle strobes and no wait state.
*/
module tb_top import capw_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic             clk, nrst, wr, rd, idle, clr, wd;
   logic [4:0]       addr;
   logic [7:0]       wdata, rdata, rv;
   logic [2:0]       chan_out;
   logic [2:0][15:0] hi;
   logic [15:0]      h;
   int               fails, checks_done, n, v;

   capw_pwm_wdt #(.NCH(3)) i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .idle(idle), .rdata(rdata), .chan_out(chan_out), .wdt_rst(wd));
   capw_load i_load (.clk(clk), .clr(clr), .pins(chan_out), .hi(hi));

   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask
   task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask
   // Window of two whole periods, so the phase of the clear does not matter
   task automatic duty(input int p, input int ch, output logic [15:0] c);
      repeat (2 * p) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (2 * p) @(posedge clk);
      #1 c = hi[ch];
   endtask
   function automatic logic [15:0] exp_hi(input int bits, input int val);
      return 16'(2 * ((1 << bits) - val));
   endfunction
   task automatic wrap_up;
      if (fails == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ==========================================================
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      wrap_up;
   end

   // ==========================================================
   // Main sequence
   initial begin
      {nrst, wr, rd, idle, clr} = '0;
      addr = '0;
      wdata = '0;
      fails = 0;
      checks_done = 0;
      void'($urandom(65));
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      n = 0;
      while (wd !== 1'b1 && n < 4000) begin
         @(posedge clk);
         #1 n++;
      end
      chk("wdt timeout", 16'(n >= 3060 && n <= 3100), 16'h0001);
      rd_reg(A_MODE, rv);
      chk("mode reset", {8'h00, rv}, 16'h0040);
      rd_reg(A_CTRL, rv);
      chk("run reads 0", {8'h00, rv}, 16'h0000);
      // Watchdog off first, so the fast prescaler setting is not frozen
      wr_reg(A_MODE, 8'h00);
      wr_reg(A_MODE, 8'h04);
      wr_reg(A_CTRL, 8'h40);
      rd_reg(A_CTRL, rv);
      chk("run bit", {8'h00, rv & 8'h40}, 16'h0040);
      wr_reg(A_PWMC, 8'h00);
      for (int i = 0; i < 3; i++) begin
         v = (i == 0) ? 0 : (i == 1) ? 255 : $urandom_range(254, 1);
         wr_reg(A_CH0 + A_CPM, 8'h42);
         wr_reg(A_CH0 + A_CPL, 8'(v));
         rd_reg(A_CH0, rv);
         chk("ecom low", {8'h00, rv}, 16'h0002);
         wr_reg(A_CH0 + A_CPH, 8'(v));
         rd_reg(A_CH0, rv);
         chk("ecom high", {8'h00, rv}, 16'h0042);
         duty(256, 0, h);
         chk("duty 8", h, exp_hi(8, v));
      end
      wr_reg(A_CH0 + A_CPL, 8'h10);
      duty(256, 0, h);
      chk("duty off", h, 16'h0000);
      for (int b = 9; b <= 11; b++) begin
         v = $urandom_range((1 << b) - 1, 0);
         wr_reg(A_PWMC, 8'h80 | 8'(b - 8));
         wr_reg(A_CH0 + 5'h04 + A_CPL, v[7:0]);
         wr_reg(A_CH0 + 5'h04 + A_CPH, v[15:8]);
         wr_reg(A_CH0 + 5'h04, 8'h42);
         duty(1 << b, 1, h);
         chk("duty n", h, exp_hi(b, v));
      end
      rd_reg(A_PWMC, rv);
      chk("cycle ovf", {8'h00, rv}, 16'h00c3);
      // Wide PWM on channel 2, count started just below a match near the top
      wr_reg(A_PWMC, 8'h00);
      wr_reg(A_CH0 + 5'h08 + A_CPM, 8'hca);
      wr_reg(A_CH0 + 5'h08 + A_CPL, 8'hf8);
      wr_reg(A_CH0 + 5'h08 + A_CPH, 8'hff);
      wr_reg(A_CTRL, 8'h40);
      wr_reg(A_CNTL, 8'h00);
      wr_reg(A_CNTH, 8'hff);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (300) @(posedge clk);
      #1 chk("duty 16", hi[2], exp_hi(16, 'hfff8) >> 1);
      rd_reg(A_CTRL, rv);
      chk("wide flags", {8'h00, rv}, 16'h00c4);
      // Next match value only once the match flag has been seen
      wr_reg(A_CH0 + 5'h08 + A_CPL, 8'h10);
      wr_reg(A_CNTL, 8'h00);
      wr_reg(A_CNTH, 8'h20);
      // Lock, then a clear of the enable must not turn the watchdog off
      wr_reg(A_MODE, 8'h24);
      wr_reg(A_MODE, 8'h00);
      wr_reg(A_CH0 + 5'h08 + A_CPH, 8'($urandom));
      wr_reg(A_CNTL, 8'hff);
      rd_reg(A_CH0 + 5'h08 + A_CPH, rv);
      chk("wdt update", {8'h00, rv}, 16'h0030);
      rd_reg(A_CNTH, rv);
      chk("count frozen", {8'h00, rv}, 16'h0020);
      wr_reg(A_CTRL, 8'h44);
      #1 chk("forced reset", {15'h0000, wd}, 16'h0001);
      wrap_up;
   end
endmodule
